// [shared/wkt_pkg.sv]
// Package for the wake-up timer block: register map, fields, states.
// Assumes an 8-bit register port with byte addresses.
`default_nettype none
package wkt_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_T3_COUNT_HIGH = 8'h21;
    localparam logic [7:0] ADDR_T3_COUNT_LOW  = 8'h22;
    localparam logic [7:0] ADDR_CONTROL       = 8'h23;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h24;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h25;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h26;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'h27;
    localparam logic [7:0] ADDR_STATUS        = 8'h2c;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int BIT_RUNNING     = 7;
    localparam int BIT_PERMIT      = 6;
    localparam int BIT_AUTO_TRIM   = 5;
    localparam int BIT_AUTO_CHECK  = 4;
    localparam int BIT_AUTO_RELOAD = 3;
    localparam int BIT_AUTO_WAKE   = 2;

    localparam logic [1:0] CLK_DIV1  = 2'h0;
    localparam logic [1:0] CLK_DIV8  = 2'h1;
    localparam logic [1:0] CLK_DIV16 = 2'h2;
    localparam logic [1:0] CLK_DIV32 = 2'h3;

    localparam logic [4:0] DIV8_LAST  = 5'h07;
    localparam logic [4:0] DIV16_LAST = 5'h0f;
    localparam logic [4:0] DIV32_LAST = 5'h1f;

    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;
    localparam logic [4:0]  PRESC_ZERO  = 5'h00;
    localparam logic [4:0]  PRESC_ONE   = 5'h01;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic       auto_trim;
        logic       auto_check;
        logic       auto_reload;
        logic       auto_wake;
        logic [1:0] clock_select;
    } wkt_ctrl_t;

    localparam wkt_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0};

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wkt_bus_t;

    // Card check sequence; IDLE to FIELD and FIELD to EVAL each change one bit, EVAL to IDLE two
    typedef enum logic [1:0] {
        CHK_IDLE  = 2'b00,
        CHK_FIELD = 2'b01,
        CHK_EVAL  = 2'b11
    } wkt_chk_t;

endpackage : wkt_pkg
`default_nettype wire

// [src/wkt_prescaler.sv]
// Slow oscillator tick divider for the wake-up timer.
// Assumes slow_tick_in is a one-cycle pulse synchronous to ref_clk_in.
`default_nettype none
module wkt_prescaler
    import wkt_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       run_in,
    input  wire logic       slow_tick_in,
    input  wire logic [1:0] select_in,
    output logic            tick_out
);

    logic [4:0] presc_q;
    logic [4:0] last;

    always_comb begin
        unique case (select_in)
            CLK_DIV1:  last = PRESC_ZERO;
            CLK_DIV8:  last = DIV8_LAST;
            CLK_DIV16: last = DIV16_LAST;
            CLK_DIV32: last = DIV32_LAST;
        endcase
    end

    // Restarts from zero when stopped, so each start from stop gets a full first period
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            presc_q <= PRESC_ZERO;
        end else if (!run_in) begin
            presc_q <= PRESC_ZERO;
        end else if (slow_tick_in) begin
            presc_q <= (presc_q >= last) ? PRESC_ZERO : presc_q + PRESC_ONE;
        end
    end

    assign tick_out = run_in && slow_tick_in && (presc_q >= last);

endmodule // wkt_prescaler
`default_nettype wire

// [src/wkt_wakeup_timer.sv]
// Wake-up timer with count readout and timer 3 count readout.
// Assumes a synchronous register port and a slow oscillator tick pulse.
`default_nettype none

module wkt_wakeup_timer
    import wkt_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        slow_tick_in,
    input  wire logic [15:0] timer3_count_in,
    input  wire logic        timer3_underflow_in,
    input  wire logic        card_result_valid_in,
    input  wire logic        card_present_in,
    output logic             trim_start_out,
    output logic             field_on_out,
    output logic             timer3_start_out,
    output logic             card_irq_out,
    output logic             wake_out,
    output logic             power_down_out,
    output logic             underflow_flag_out
);

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    wkt_bus_t  bus;
    wkt_ctrl_t ctrl_q;
    logic      running_q;
    logic [7:0] reload_high_q;
    logic [7:0] reload_low_q;
    logic [15:0] count_q;
    logic      flag_q;
    logic      tick;
    logic      underflow;
    logic      start_evt;
    logic      stop_evt;
    logic      ctrl_wr;
    logic      status_rd;
    wkt_chk_t  chk_q;

    assign bus = '{write_in, read_in, addr_in, wdata_in};
    assign ctrl_wr   = bus.write && (bus.addr == ADDR_CONTROL);
    assign start_evt = ctrl_wr && bus.wdata[BIT_PERMIT] && bus.wdata[BIT_RUNNING];
    assign stop_evt  = ctrl_wr && bus.wdata[BIT_PERMIT] && !bus.wdata[BIT_RUNNING];
    assign status_rd = bus.read && (bus.addr == ADDR_STATUS);

    function automatic logic [7:0] read_mux(input logic [7:0] a);
        unique case (a)
            ADDR_T3_COUNT_HIGH: read_mux = timer3_count_in[15:8];
            ADDR_T3_COUNT_LOW:  read_mux = timer3_count_in[7:0];
            ADDR_CONTROL:       read_mux = {running_q, 1'b0, ctrl_q};
            ADDR_RELOAD_HIGH:   read_mux = reload_high_q;
            ADDR_RELOAD_LOW:    read_mux = reload_low_q;
            ADDR_COUNT_HIGH:    read_mux = count_q[15:8];
            ADDR_COUNT_LOW:     read_mux = count_q[7:0];
            ADDR_STATUS:        read_mux = {7'h00, flag_q};
            default:            read_mux = RESET_BYTE;
        endcase
    endfunction

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= RESET_BYTE;
        end else if (bus.read) begin
            rdata_out <= read_mux(bus.addr);
        end else begin
            rdata_out <= RESET_BYTE;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= wkt_ctrl_t'(bus.wdata[5:0]);
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reload_high_q <= RESET_BYTE;
            reload_low_q  <= RESET_BYTE;
        end else if (bus.write) begin
            if (bus.addr == ADDR_RELOAD_HIGH) begin
                reload_high_q <= bus.wdata;
            end
            if (bus.addr == ADDR_RELOAD_LOW) begin
                reload_low_q <= bus.wdata;
            end
        end
    end

    // ----------------------------------------
    // Countdown
    // ----------------------------------------
    wkt_prescaler u_prescaler (
        .ref_clk_in   (ref_clk_in),
        .reset_n_in   (reset_n_in),
        .run_in       (running_q),
        .slow_tick_in (slow_tick_in),
        .select_in    (ctrl_q.clock_select),
        .tick_out     (tick)
    );

    assign underflow = tick && (count_q == RESET_COUNT);

    // Card checking forces a gapless restart even without auto-reload
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            running_q <= 1'b0;
        end else if (start_evt) begin
            running_q <= 1'b1;
        end else if (stop_evt) begin
            running_q <= 1'b0;
        end else if (underflow && !ctrl_q.auto_reload && !ctrl_q.auto_check) begin
            running_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= RESET_COUNT;
        end else if (start_evt) begin
            count_q <= {reload_high_q, reload_low_q};
        end else if (underflow) begin
            if (ctrl_q.auto_reload || ctrl_q.auto_check) begin
                count_q <= {reload_high_q, reload_low_q};
            end
        end else if (tick) begin
            count_q <= count_q - COUNT_ONE;
        end
    end

    // ----------------------------------------
    // Underflow flag, set wins over read-clear
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_q <= 1'b0;
        end else if (underflow) begin
            flag_q <= 1'b1;
        end else if (status_rd) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            underflow_flag_out <= 1'b0;
        end else if (underflow) begin
            underflow_flag_out <= 1'b1;
        end else if (status_rd) begin
            underflow_flag_out <= 1'b0;                          // Drops with the clearing read
        end
    end

    // ----------------------------------------
    // Underflow actions
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trim_start_out <= 1'b0;
            wake_out       <= 1'b0;
        end else begin
            trim_start_out <= underflow && ctrl_q.auto_trim;
            wake_out       <= underflow && ctrl_q.auto_wake;
        end
    end

    // ----------------------------------------
    // Card check sequence
    // ----------------------------------------
    // Field window is timed by timer 3; result arrives from the detector
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chk_q <= CHK_IDLE;
        end else begin
            unique case (chk_q)
                CHK_IDLE: begin
                    if (underflow && ctrl_q.auto_check) begin
                        chk_q <= CHK_FIELD;
                    end
                end
                CHK_FIELD: begin
                    if (timer3_underflow_in) begin
                        chk_q <= CHK_EVAL;
                    end
                end
                CHK_EVAL: begin
                    if (card_result_valid_in) begin
                        chk_q <= CHK_IDLE;
                    end
                end
                default: chk_q <= CHK_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer3_start_out <= 1'b0;
            field_on_out     <= 1'b0;
        end else begin
            timer3_start_out <= (chk_q == CHK_IDLE) && underflow && ctrl_q.auto_check;
            field_on_out     <= (chk_q == CHK_IDLE) ? (underflow && ctrl_q.auto_check)
                                : (chk_q == CHK_FIELD) && !timer3_underflow_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            card_irq_out   <= 1'b0;
            power_down_out <= 1'b0;
        end else begin
            card_irq_out   <= (chk_q == CHK_EVAL) && card_result_valid_in && card_present_in;
            power_down_out <= (chk_q == CHK_EVAL) && card_result_valid_in && !card_present_in
                              && ctrl_q.auto_wake;
        end
    end

endmodule // wkt_wakeup_timer
`default_nettype wire

// [bench/wkt_wakeup_timer_asserts.sv]
// Port-level properties of the wake-up timer block.
// Assumes it is bound onto wkt_wakeup_timer.
`default_nettype none
module wkt_wakeup_timer_asserts
    import wkt_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic        read_in,
    input  wire logic [7:0]  rdata_out,
    input  wire logic [15:0] timer3_count_in,
    input  wire logic        timer3_underflow_in,
    input  wire logic        card_result_valid_in,
    input  wire logic        card_present_in,
    input  wire logic        field_on_out,
    input  wire logic        trim_start_out,
    input  wire logic        card_irq_out,
    input  wire logic        power_down_out,
    input  wire logic        underflow_flag_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_rd(logic [7:0] a);
        read_in && addr_in == a;
    endsequence

    property p_t3_low;
        s_rd(ADDR_T3_COUNT_LOW) |=> rdata_out == $past(timer3_count_in[7:0]);
    endproperty
    a_t3_low: assert property (p_t3_low) else $error("timer3 low byte readout wrong");
    property p_t3_high;
        s_rd(ADDR_T3_COUNT_HIGH) |=> rdata_out == $past(timer3_count_in[15:8]);
    endproperty
    a_t3_high: assert property (p_t3_high) else $error("timer3 high byte readout wrong");
    property p_permit_zero;
        s_rd(ADDR_CONTROL) |=> rdata_out[BIT_PERMIT] == 1'b0;
    endproperty
    a_permit_zero: assert property (p_permit_zero) else $error("permit bit read back set");
    property p_flag_read;
        s_rd(ADDR_STATUS) |=> rdata_out[0] == $past(underflow_flag_out);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("status read misses flag");
    // Flag is sticky: only a status read may clear it
    property p_flag_sticky;
        $fell(underflow_flag_out) |-> $past(read_in && addr_in == ADDR_STATUS);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without read");
    property p_field_off;
        field_on_out && timer3_underflow_in |=> !field_on_out;
    endproperty
    a_field_off: assert property (p_field_off) else $error("field stays on after timer3");
    property p_irq_cause;
        card_irq_out |-> $past(card_result_valid_in && card_present_in);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("card irq without card");
    property p_pdown_cause;
        power_down_out |-> $past(card_result_valid_in && !card_present_in);
    endproperty
    a_pdown_cause: assert property (p_pdown_cause) else $error("power-down without empty result");
    property p_trim_pulse;
        trim_start_out |=> !trim_start_out;
    endproperty
    a_trim_pulse: assert property (p_trim_pulse) else $error("trim start longer than a cycle");
endmodule // wkt_wakeup_timer_asserts

bind wkt_wakeup_timer wkt_wakeup_timer_asserts u_chk (.ref_clk_in, .reset_n_in, .addr_in, .read_in,
    .rdata_out, .timer3_count_in, .timer3_underflow_in, .card_result_valid_in, .card_present_in,
    .field_on_out, .trim_start_out, .card_irq_out, .power_down_out, .underflow_flag_out);
`default_nettype wire

// [bench/wkt_wakeup_timer_test.sv]
// Self-checking bench for the wake-up timer through its register port.
// Assumes the bench plays host, slow oscillator, timer 3 and detector.
`default_nettype none
module wkt_wakeup_timer_test
    import wkt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_in, reset_n_in, write_in, read_in, slow_tick_in;
    logic [7:0]  addr_in, wdata_in, rdata_out;
    logic [15:0] timer3_count_in;
    logic        timer3_underflow_in, card_result_valid_in, card_present_in;
    logic        trim_start_out, field_on_out, timer3_start_out, card_irq_out;
    logic        wake_out, power_down_out, underflow_flag_out;
    int          error_cnt, checks, n;
    int          pc [5];

    wkt_wakeup_timer uut (.ref_clk_in, .reset_n_in, .addr_in, .wdata_in, .write_in, .read_in,
        .rdata_out, .slow_tick_in, .timer3_count_in, .timer3_underflow_in, .card_result_valid_in,
        .card_present_in, .trim_start_out, .field_on_out, .timer3_start_out, .card_irq_out,
        .wake_out, .power_down_out, .underflow_flag_out);

    // ----------------------------------------
    // Clock, pulse tallies, tasks
    // ----------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Event outputs last one cycle, so tally them every edge
    always @(posedge ref_clk_in) begin
        pc[0] += int'(trim_start_out === 1'b1);
        pc[1] += int'(wake_out === 1'b1);
        pc[2] += int'(timer3_start_out === 1'b1);
        pc[3] += int'(card_irq_out === 1'b1);
        pc[4] += int'(power_down_out === 1'b1);
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge ref_clk_in);
        write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge ref_clk_in);
        read_in <= 1'b0;
        #1 chk(nm, rdata_out, e);
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge ref_clk_in);
            slow_tick_in <= 1'b1;
            @(posedge ref_clk_in);
            slow_tick_in <= 1'b0;
            @(posedge ref_clk_in);
        end
        repeat (3) @(posedge ref_clk_in);
    endtask
    task automatic ev(input logic t3u, input logic vld, input logic present);
        @(posedge ref_clk_in);
        timer3_underflow_in  <= t3u;
        card_result_valid_in <= vld;
        card_present_in      <= present;
        @(posedge ref_clk_in);
        timer3_underflow_in  <= 1'b0;
        card_result_valid_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        #400us;
        error_cnt++;
        end_of_test();
    end
    initial begin
        {reset_n_in, write_in, read_in, slow_tick_in, timer3_underflow_in} = '0;
        {card_result_valid_in, card_present_in, addr_in, wdata_in} = '0;
        timer3_count_in = 16'ha55a;
        repeat (5) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        rd(ADDR_CONTROL, 8'h00, "ctrl_rst");
        rd(ADDR_COUNT_HIGH, 8'h00, "cnt_hi_rst");
        rd(ADDR_T3_COUNT_HIGH, 8'ha5, "t3_hi");
        rd(ADDR_T3_COUNT_LOW, 8'h5a, "t3_lo");
        rd(8'h30, 8'h00, "unmapped");
        wr(ADDR_COUNT_LOW, 8'hff);
        rd(ADDR_COUNT_LOW, 8'h00, "cnt_lo_ro");
        wr(ADDR_RELOAD_HIGH, 8'h00);
        wr(ADDR_RELOAD_LOW, 8'h03);
        rd(ADDR_RELOAD_LOW, 8'h03, "reload_lo");
        wr(ADDR_CONTROL, 8'h80);
        rd(ADDR_CONTROL, 8'h00, "no_permit");
        wr(ADDR_CONTROL, 8'hc0);
        rd(ADDR_CONTROL, 8'h80, "started");
        rd(ADDR_COUNT_LOW, 8'h03, "loaded");
        wr(ADDR_RELOAD_LOW, 8'h05);
        tick(2);
        rd(ADDR_COUNT_LOW, 8'h01, "decrement");
        tick(2);
        rd(ADDR_CONTROL, 8'h00, "stopped");
        chk("flag_pin", 8'(underflow_flag_out), 8'h01);
        rd(ADDR_STATUS, 8'h01, "flag_set");
        rd(ADDR_STATUS, 8'h00, "flag_clr");
        chk("flag_pin_clr", 8'(underflow_flag_out), 8'h00);
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 1 : (4 << c);
            wr(ADDR_CONTROL, 8'h40);
            wr(ADDR_CONTROL, 8'hc0 | 8'(c));
            tick(n - 1);
            rd(ADDR_COUNT_LOW, 8'h05, "div_hold");
            tick(1);
            rd(ADDR_COUNT_LOW, 8'h04, "div_step");
        end
        wr(ADDR_CONTROL, 8'h40);
        wr(ADDR_RELOAD_LOW, 8'h01);
        wr(ADDR_CONTROL, 8'hec);
        tick(2);
        chk("trim", 8'(pc[0]), 8'h01);
        chk("wake", 8'(pc[1]), 8'h01);
        rd(ADDR_COUNT_LOW, 8'h01, "reloaded");
        rd(ADDR_CONTROL, 8'hac, "ctrl_rw");
        wr(ADDR_CONTROL, 8'h40);
        wr(ADDR_CONTROL, 8'hd0);
        tick(2);
        chk("field_on", 8'(field_on_out), 8'h01);
        chk("t3_start", 8'(pc[2]), 8'h01);
        rd(ADDR_COUNT_LOW, 8'h01, "no_gap");
        ev(1'b1, 1'b0, 1'b0);
        chk("field_off", 8'(field_on_out), 8'h00);
        ev(1'b0, 1'b1, 1'b1);
        chk("card_irq", 8'(pc[3]), 8'h01);
        wr(ADDR_CONTROL, 8'h14);
        rd(ADDR_CONTROL, 8'h94, "keep_run");
        tick(2);
        ev(1'b1, 1'b0, 1'b0);
        ev(1'b0, 1'b1, 1'b0);
        chk("power_down", 8'(pc[4]), 8'h01);
        chk("wake2", 8'(pc[1]), 8'h02);
        end_of_test();
    end
endmodule // wkt_wakeup_timer_test
`default_nettype wire
